// *** rtl/icb_ahb.sv ***
// AHB-Lite slave that turns word transfers into register strobes.
`timescale 1ns/1ns
`default_nettype none
module icb_ahb
   import icb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   icb_reg_if.bus regs
);
   logic pend_q;
   logic done_q;
   logic wr_q;
   logic map_q;
   logic [7:0] addr_q;
   wire take = hsel && htrans[1] && hready;
   wire strobe = pend_q && !done_q;

   // Every data phase takes one wait state so reads come from a flop.
   assign hreadyout = !pend_q || done_q;
   assign hresp = 1'b0;
   assign regs.wr = strobe && wr_q && map_q;
   assign regs.rd = strobe && !wr_q && map_q;
   assign regs.addr = addr_q;
   assign regs.wdata = hwdata;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pend_q <= 1'b0;
         done_q <= 1'b0;
         wr_q <= 1'b0;
         map_q <= 1'b0;
         addr_q <= 8'h00;
         hrdata <= 32'h0000_0000;
      end
      else if (take)
      begin
         pend_q <= 1'b1;
         done_q <= 1'b0;
         wr_q <= hwrite;
         map_q <= haddr[31:8] == 24'h00_0000;
         addr_q <= haddr[7:0];
      end
      else if (done_q)
      begin
         pend_q <= 1'b0;
         done_q <= 1'b0;
      end
      else if (pend_q)
      begin
         done_q <= 1'b1;
         hrdata <= (!wr_q && map_q) ? regs.rdata : 32'h0000_0000;
      end
   end
endmodule : icb_ahb
`default_nettype wire

// *** rtl/icb_channel.sv ***
// I/O channel core: instruction registers, block sequencer, unit pins.
//
// Local design decisions: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module icb_channel
   import icb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic mem_req,
   output logic mem_we,
   output logic [ICB_AW-1:0] mem_addr,
   output logic [ICB_DW-1:0] mem_wdata,
   input wire logic [ICB_DW-1:0] mem_rdata,
   input wire logic mem_grant,
   input wire logic [ICB_DW-1:0] unit_din,
   input wire logic unit_data_avail,
   input wire logic unit_accepted,
   input wire logic unit_connected,
   input wire logic unit_reconnecting,
   input wire logic unit_xfer_req,
   input wire logic unit_addr_here,
   input wire logic unit_input,
   input wire logic [ICB_AW-1:0] unit_addr_in,
   input wire logic unit_count_en,
   output logic [ICB_DW-1:0] unit_dout,
   output logic unit_data_here,
   output logic unit_accept,
   output logic unit_wc_done,
   output logic init_intr
);
   localparam int PW = ICB_DW + ICB_AW + 8;

   logic rst_meta_q;
   logic rst_n_q;
   logic [PW-1:0] pin_raw;
   logic [PW-1:0] pin_s;
   logic [ICB_DW-1:0] u_din;
   logic [ICB_AW-1:0] u_addr;
   logic u_avail;
   logic u_acc;
   logic u_conn;
   logic u_dcs;
   logic u_dtr;
   logic u_ahere;
   logic u_in;
   logic u_cnt;

   icb_state_e state_q;
   icb_state_e ret_q;
   icb_style_e style_q;
   logic blk_q;
   logic dir_q;
   logic rev_q;
   logic restart_q;
   logic reinit_q;
   logic x_in_q;
   logic ext_q;
   logic refused_q;
   logic data_here_q;
   logic avail_d_q;
   logic dtr_d_q;
   logic avail_ev_q;
   logic [1:0] pidx_q;
   logic [ICB_AW-1:0] tar_q;
   logic [ICB_AW-1:0] setup_ptr_q;
   logic [ICB_WCW-1:0] wcr_q;
   logic [ICB_SKW-1:0] skip_q;
   logic [ICB_DW-1:0] out_buf_q;
   logic [ICB_DW-1:0] in_buf_q;
   logic [4:0] status;

   icb_reg_if regs ();

   // The rest of the design sees a reset whose release is clocked.
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   assign pin_raw = {unit_din, unit_addr_in, unit_data_avail,
      unit_accepted, unit_connected, unit_reconnecting, unit_xfer_req,
      unit_addr_here, unit_input, unit_count_en};
   assign {u_din, u_addr, u_avail, u_acc, u_conn, u_dcs, u_dtr,
      u_ahere, u_in, u_cnt} = pin_s;

   icb_sync #(.W(PW)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n_q),
      .d(pin_raw),
      .q(pin_s)
   );

   icb_ahb u_ahb (
      .clk_sys(clk_sys),
      .rst_n(rst_n_q),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .regs(regs)
   );

   wire is_bbc = style_q == ICB_BBC;
   wire is_xbc = style_q == ICB_XBC;
   wire is_ibc = style_q == ICB_IBC;
   wire wr_cmd = regs.wr && regs.addr == ICB_OFF_CMD;
   wire wr_data = regs.wr && regs.addr == ICB_OFF_DATA;
   wire wr_addr = regs.wr && regs.addr == ICB_OFF_ADDR;
   wire wr_ctrl = regs.wr && regs.addr == ICB_OFF_CTRL;
   wire rd_data = regs.rd && regs.addr == ICB_OFF_DATA;
   wire rd_addr = regs.rd && regs.addr == ICB_OFF_ADDR;
   wire rd_setup = regs.rd && regs.addr == ICB_OFF_SETUP;
   wire rd_unit = regs.rd && regs.addr == ICB_OFF_UNIT;
   wire rd_status = regs.rd && regs.addr == ICB_OFF_STATUS;
   wire rd_ctrl = regs.rd && regs.addr == ICB_OFF_CTRL;
   wire [ICB_DW-1:0] wd = regs.wdata[ICB_DW-1:0];

   // An output word still owed to the unit keeps the channel busy.
   wire hs_busy = state_q == ST_OUT_HS;
   wire chan_busy = state_q != ST_IDLE || blk_q;
   wire ovr_ok = is_bbc && blk_q && wd[ICB_CMD_OVR];
   wire ocw_ok = wr_cmd && (!chan_busy || ovr_ok);
   wire odw_ok = wr_data && !chan_busy;
   wire idw_ok = rd_data && !chan_busy && !u_dcs && u_avail;
   wire isw_ok = rd_unit && !hs_busy && u_conn;
   wire oaw_ok = wr_addr && (is_bbc || !chan_busy);
   wire ia_ok = is_bbc || (is_ibc && !chan_busy);
   wire iaw_ok = rd_addr && ia_ok;
   wire ipw_ok = rd_setup && ia_ok;
   wire instr = wr_cmd || wr_data || wr_addr || rd_data || rd_addr ||
      rd_setup || rd_unit;
   wire instr_ok = ocw_ok || odw_ok || oaw_ok || idw_ok || iaw_ok ||
      ipw_ok || isw_ok;
   wire hs_start = ocw_ok || odw_ok || (oaw_ok && is_xbc);
   wire avail_rise = u_avail && !avail_d_q;
   wire dtr_rise = u_dtr && !dtr_d_q;
   wire [ICB_AW-1:0] tar_step = rev_q ? tar_q - 1'b1 : tar_q + 1'b1;
   wire [ICB_WCW-1:0] wcr_dec = wcr_q - 1'b1;
   wire chain_now = reinit_q && mem_rdata[ICB_P2_CHAIN];
   wire fetch_last = pidx_q == 2'd2 || (pidx_q == 2'd1 && !chain_now);
   wire ibc_step = is_ibc && u_cnt && !ext_q;

   assign status[ICB_ST_BUSY] = chan_busy;
   assign status[ICB_ST_BLOCK] = blk_q;
   assign status[ICB_ST_REFUSED] = refused_q;
   assign status[ICB_ST_INPUT] = dir_q;
   assign status[ICB_ST_SKIP] = skip_q != '0;

   // A refused input instruction reads as zero, like a failed transfer.
   assign regs.rdata = idw_ok ? 32'(u_din) :
      isw_ok ? 32'(u_din) :
      iaw_ok ? 32'(tar_q) :
      ipw_ok ? 32'(setup_ptr_q) :
      rd_status ? 32'(status) :
      rd_ctrl ? 32'(style_q) : 32'h0000_0000;

   assign mem_req = state_q == ST_PFETCH || state_q == ST_OUT_MEM ||
      state_q == ST_IN_MEM || state_q == ST_X_MEM;
   assign mem_we = state_q == ST_IN_MEM || (state_q == ST_X_MEM && x_in_q);
   assign mem_addr = state_q == ST_PFETCH ? setup_ptr_q : tar_q;
   assign mem_wdata = in_buf_q;
   assign unit_dout = out_buf_q;
   assign unit_data_here = data_here_q;

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         style_q <= ICB_CTRL_RST;
         refused_q <= 1'b0;
         avail_d_q <= 1'b0;
         dtr_d_q <= 1'b0;
         avail_ev_q <= 1'b0;
      end
      else
      begin
         if (wr_ctrl && wd[1:0] != 2'b11)
            style_q <= icb_style_e'(wd[1:0]);
         if (instr)
            refused_q <= !instr_ok;
         avail_d_q <= u_avail;
         dtr_d_q <= u_dtr;
         // A new data-ready edge wins over the one being consumed.
         avail_ev_q <= avail_rise ||
            (avail_ev_q && state_q != ST_IN_WAIT);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         state_q <= ST_IDLE;
         ret_q <= ST_IDLE;
         blk_q <= 1'b0;
         dir_q <= 1'b0;
         rev_q <= 1'b0;
         restart_q <= 1'b0;
         reinit_q <= 1'b0;
         x_in_q <= 1'b0;
         ext_q <= 1'b0;
         data_here_q <= 1'b0;
         pidx_q <= 2'd0;
         tar_q <= '0;
         setup_ptr_q <= '0;
         wcr_q <= '0;
         skip_q <= '0;
         out_buf_q <= '0;
         in_buf_q <= '0;
         unit_accept <= 1'b0;
         unit_wc_done <= 1'b0;
         init_intr <= 1'b0;
      end
      else
      begin
         unit_accept <= idw_ok;
         unit_wc_done <= 1'b0;
         init_intr <= oaw_ok && is_bbc;
         if (oaw_ok && !is_xbc)
            setup_ptr_q <= wd[ICB_AW-1:0];
         if (hs_start)
         begin
            out_buf_q <= wd;
            data_here_q <= 1'b0;
            state_q <= ST_OUT_HS;
            ret_q <= ST_IDLE;
            if (ocw_ok)
            begin
               blk_q <= is_bbc && wd[ICB_CMD_BLOCK];
               dir_q <= wd[ICB_CMD_DIR];
               rev_q <= wd[ICB_CMD_REV];
               ext_q <= 1'b0;
               reinit_q <= 1'b0;
               pidx_q <= 2'd0;
               if (wd[ICB_CMD_BLOCK] && !is_xbc)
                  ret_q <= ST_PFETCH;
            end
         end
         else
         begin
            unique case (state_q)
               ST_IDLE:
               begin
                  data_here_q <= 1'b0;
                  if (!is_bbc && dtr_rise)
                  begin
                     x_in_q <= u_in;
                     if (is_ibc && u_ahere && u_in)
                     begin
                        tar_q <= u_addr;
                        ext_q <= 1'b1;
                     end
                     else
                     begin
                        if (is_xbc)
                           tar_q <= u_addr;
                        if (u_in)
                        begin
                           in_buf_q <= u_din;
                           unit_accept <= 1'b1;
                        end
                        state_q <= ST_X_MEM;
                     end
                  end
               end
               ST_OUT_HS:
               begin
                  if (!data_here_q)
                  begin
                     if ((!u_dcs || u_conn) && !u_acc)
                        data_here_q <= 1'b1;
                  end
                  else if (u_acc)
                  begin
                     data_here_q <= 1'b0;
                     state_q <= ret_q;
                  end
               end
               ST_PFETCH:
               begin
                  if (mem_grant)
                  begin
                     setup_ptr_q <= setup_ptr_q + 1'b1;
                     pidx_q <= pidx_q + 1'b1;
                     if (pidx_q == 2'd0)
                     begin
                        wcr_q <= mem_rdata[ICB_WCW-1:0];
                        skip_q <= mem_rdata[ICB_P1_SKIP_LSB +: ICB_SKW];
                     end
                     else if (pidx_q == 2'd1)
                     begin
                        tar_q <= mem_rdata[ICB_AW-1:0];
                        restart_q <= mem_rdata[ICB_P2_RESTART];
                     end
                     else
                     begin
                        out_buf_q <= mem_rdata;
                        dir_q <= mem_rdata[ICB_CMD_DIR];
                        rev_q <= mem_rdata[ICB_CMD_REV];
                     end
                     if (fetch_last && pidx_q == 2'd2)
                     begin
                        ret_q <= ST_RUN;
                        state_q <= ST_OUT_HS;
                     end
                     else if (fetch_last)
                        state_q <= blk_q ? ST_RUN : ST_IDLE;
                  end
               end
               ST_RUN:
               begin
                  if (wcr_q == '0)
                  begin
                     if (restart_q)
                     begin
                        reinit_q <= 1'b1;
                        pidx_q <= 2'd0;
                        state_q <= ST_PFETCH;
                     end
                     else
                     begin
                        blk_q <= 1'b0;
                        state_q <= ST_IDLE;
                     end
                  end
                  else
                     state_q <= dir_q ? ST_IN_WAIT : ST_OUT_MEM;
               end
               ST_OUT_MEM:
               begin
                  if (mem_grant)
                  begin
                     tar_q <= tar_step;
                     wcr_q <= wcr_dec;
                     out_buf_q <= mem_rdata;
                     ret_q <= ST_RUN;
                     state_q <= ST_OUT_HS;
                  end
               end
               ST_IN_WAIT:
               begin
                  if (avail_ev_q)
                  begin
                     in_buf_q <= u_din;
                     unit_accept <= 1'b1;
                     if (skip_q != '0)
                        skip_q <= skip_q - 1'b1;
                     else
                        state_q <= ST_IN_MEM;
                  end
               end
               ST_IN_MEM:
               begin
                  if (mem_grant)
                  begin
                     tar_q <= tar_step;
                     wcr_q <= wcr_dec;
                     state_q <= ST_RUN;
                  end
               end
               ST_X_MEM:
               begin
                  if (mem_grant)
                  begin
                     if (!x_in_q)
                        out_buf_q <= mem_rdata;
                     if (ibc_step)
                     begin
                        tar_q <= tar_q + 1'b1;
                        wcr_q <= wcr_dec;
                        if (wcr_q == 16'h0001 && !restart_q)
                           unit_wc_done <= 1'b1;
                     end
                     if (!x_in_q && is_xbc)
                     begin
                        // A stale return state would restart a fetch.
                        ret_q <= ST_IDLE;
                        state_q <= ST_OUT_HS;
                     end
                     else
                     begin
                        // Integrated output strobes the word, no reply.
                        data_here_q <= !x_in_q;
                        state_q <= ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end
endmodule : icb_channel
`default_nettype wire

// *** rtl/icb_pkg.sv ***
// Shared constants and types for the I/O channel block transfer logic.
package icb_pkg;
   localparam int ICB_AW = 20;
   localparam int ICB_DW = 24;
   localparam int ICB_WCW = 16;
   localparam int ICB_SKW = 8;
   localparam logic [7:0] ICB_OFF_CMD = 8'h00;
   localparam logic [7:0] ICB_OFF_DATA = 8'h04;
   localparam logic [7:0] ICB_OFF_ADDR = 8'h08;
   localparam logic [7:0] ICB_OFF_SETUP = 8'h0c;
   localparam logic [7:0] ICB_OFF_STATUS = 8'h10;
   localparam logic [7:0] ICB_OFF_UNIT = 8'h14;
   localparam logic [7:0] ICB_OFF_CTRL = 8'h18;
   localparam int ICB_CMD_BLOCK = 23;
   localparam int ICB_CMD_DIR = 22;
   localparam int ICB_CMD_REV = 21;
   localparam int ICB_CMD_OVR = 20;
   localparam int ICB_P2_RESTART = 23;
   localparam int ICB_P2_CHAIN = 22;
   localparam int ICB_P1_SKIP_LSB = 16;
   localparam int ICB_ST_BUSY = 0;
   localparam int ICB_ST_BLOCK = 1;
   localparam int ICB_ST_REFUSED = 2;
   localparam int ICB_ST_INPUT = 3;
   localparam int ICB_ST_SKIP = 4;
   typedef enum logic [1:0] {ICB_BBC, ICB_XBC, ICB_IBC} icb_style_e;
   localparam icb_style_e ICB_CTRL_RST = ICB_BBC;
   typedef enum logic [3:0] {
      ST_IDLE, ST_OUT_HS, ST_PFETCH, ST_RUN,
      ST_OUT_MEM, ST_IN_WAIT, ST_IN_MEM, ST_X_MEM
   } icb_state_e;
endpackage : icb_pkg

// *** rtl/icb_reg_if.sv ***
// Register strobe interface between the bus slave and the channel core.
`timescale 1ns/1ns
`default_nettype none
interface icb_reg_if;
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport bus (output wr, output rd, output addr, output wdata,
      input rdata);
   modport core (input wr, input rd, input addr, input wdata,
      output rdata);
endinterface : icb_reg_if
`default_nettype wire

// *** rtl/icb_sync.sv ***
// Two-flop synchroniser for a vector of asynchronous unit pins.
`timescale 1ns/1ns
`default_nettype none
module icb_sync
   import icb_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : icb_sync
`default_nettype wire

// *** test/icb_channel_assertions.sv ***
// Concurrent checks on the channel's top-level ports.
`timescale 1ns/1ns
`default_nettype none
module icb_channel_chk
   import icb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic mem_grant,
   input wire logic [ICB_AW-1:0] mem_addr,
   input wire logic [ICB_DW-1:0] mem_wdata,
   input wire logic [ICB_DW-1:0] unit_dout,
   input wire logic unit_data_here,
   input wire logic unit_accepted,
   input wire logic unit_accept,
   input wire logic init_intr
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   sequence s_stall;
      !hreadyout;
   endsequence
   sequence s_resume;
      hreadyout;
   endsequence
   property p_bus_wait;
      hsel && htrans[1] && hready |=> s_stall ##1 s_resume;
   endproperty
   a_bus_wait: assert property (p_bus_wait)
      else $error("bus data phase length wrong");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay)
      else $error("bus response not okay");
   property p_mem_hold;
      mem_req && !mem_grant |=> mem_req && $stable(mem_addr);
   endproperty
   a_mem_hold: assert property (p_mem_hold)
      else $error("memory request dropped early");
   property p_wdata_hold;
      mem_req && mem_we && !mem_grant |=> $stable(mem_wdata);
   endproperty
   a_wdata_hold: assert property (p_wdata_hold)
      else $error("write data moved before grant");
   property p_accept_pulse;
      unit_accept |=> !unit_accept;
   endproperty
   a_accept_pulse: assert property (p_accept_pulse)
      else $error("accept longer than one cycle");
   property p_init_pulse;
      init_intr |=> !init_intr;
   endproperty
   a_init_pulse: assert property (p_init_pulse)
      else $error("initialize pulse too long");
   property p_dout_hold;
      unit_data_here [*2] |-> $stable(unit_dout);
   endproperty
   a_dout_hold: assert property (p_dout_hold)
      else $error("output word moved in handshake");
   property p_hs_end;
      unit_accepted |-> ##[1:5] !unit_data_here;
   endproperty
   a_hs_end: assert property (p_hs_end)
      else $error("handshake not closed");
endmodule : icb_channel_chk
bind icb_channel icb_channel_chk icb_channel_chk_i (.*);
`default_nettype wire

// *** test/icb_unit_model.sv ***
// Memory and peripheral unit partner on the channel's far side.
`timescale 1ns/1ns
`default_nettype none
module icb_unit_model
   import icb_pkg::*;
(
   input wire logic clk_sys,
   input wire logic slow,
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [ICB_AW-1:0] mem_addr,
   input wire logic [ICB_DW-1:0] mem_wdata,
   output logic [ICB_DW-1:0] mem_rdata,
   output logic mem_grant,
   input wire logic [ICB_DW-1:0] unit_dout,
   input wire logic unit_data_here,
   output logic unit_accepted
);
   logic [ICB_DW-1:0] mem [64];
   logic [ICB_DW-1:0] got [$];
   logic [1:0] tick_q = 2'h0;
   wire logic [5:0] idx = mem_addr[5:0];
   // Outside a grant the read bus is inverted, so a late sample shows.
   assign mem_rdata = mem_grant ? mem[idx] : ~mem[idx];
   initial mem_grant = 1'b0;
   initial unit_accepted = 1'b0;
   always @(posedge clk_sys)
   begin
      tick_q <= tick_q + 2'h1;
      mem_grant <= mem_req && !mem_grant && (!slow || tick_q == 2'h3);
      if (mem_grant && mem_we)
         mem[idx] <= mem_wdata;
      if (unit_data_here && !unit_accepted)
         got.push_back(unit_dout);
      unit_accepted <= unit_data_here;
   end
endmodule : icb_unit_model
`default_nettype wire

// *** test/tb_icb_channel.sv ***
// Self-checking bench for the I/O channel block transfer logic.
`timescale 1ns/1ns
`default_nettype none
module tb_icb_channel;
   import icb_pkg::*;
   logic clk_sys, rstn, hsel, hwrite, hreadyout, hresp, slow;
   logic mem_req, mem_we, mem_grant, unit_data_avail, unit_accepted;
   logic unit_xfer_req, unit_input, unit_data_here, unit_accept;
   logic unit_wc_done, init_intr, unit_connected, unit_reconnecting;
   logic unit_count_en;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, seed, r;
   logic [ICB_AW-1:0] mem_addr, unit_addr_in;
   logic [ICB_DW-1:0] mem_wdata, mem_rdata, unit_din, unit_dout, w;
   logic [ICB_DW-1:0] exp_q [$];
   int miscompares, tests_run, cycles, n_init, n_wcd;
   icb_channel icb_channel_i (.hready(hreadyout), .hsize(3'b010),
      .unit_addr_here(1'b0), .*);
   icb_unit_model icb_unit_model_i (.*);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h0, a};
      hwrite <= wr;
      do @(negedge clk_sys); while (hreadyout !== 1'b1);
      @(posedge clk_sys);
      htrans <= 2'b00;
      hwdata <= d;
      do @(negedge clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
      @(posedge clk_sys);
   endtask : bus
   task automatic idle_wait();
      r = 32'h1;
      for (int i = 0; i < 200 && r[0] !== 1'b0; i++)
         bus(1'b0, ICB_OFF_STATUS, 32'h0);
      check(r & 32'h1, 32'h0);
   endtask : idle_wait
   // Pops from the tail, so a command word sent ahead of the data is ignored.
   task automatic cmp_got();
      while (exp_q.size() > 0)
         check(32'(icb_unit_model_i.got.pop_back()), 32'(exp_q.pop_back()));
      icb_unit_model_i.got.delete();
   endtask : cmp_got
   task automatic push(input logic [ICB_DW-1:0] d);
      unit_din <= d;
      unit_data_avail <= 1'b1;
      for (int i = 0; i < 50 && unit_accept !== 1'b1; i++)
         @(negedge clk_sys);
      @(posedge clk_sys);
      unit_data_avail <= 1'b0;
      repeat (8) @(posedge clk_sys);
   endtask : push
   task automatic tally_and_finish();
      if (miscompares == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish
   initial
   begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cycles <= cycles + 1;
      if (init_intr === 1'b1)
         n_init <= n_init + 1;
      if (unit_wc_done === 1'b1)
         n_wcd <= n_wcd + 1;
      if (cycles == 20000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial
   begin
      {rstn, hsel, hwrite, slow, unit_data_avail, unit_xfer_req} = 6'h0;
      {unit_input, unit_reconnecting, unit_count_en} = 3'h0;
      unit_connected = 1'b1;
      {htrans, haddr, hwdata, unit_din, unit_addr_in} = '0;
      seed = 32'h00016f43;
      {miscompares, tests_run} = '0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bus(1'b0, ICB_OFF_CTRL, 32'h0);
      check(r, 32'h0);
      bus(1'b0, 8'h1c, 32'h0);
      check(r, 32'h0);
      w = 24'(rnd());
      exp_q.push_back(w);
      bus(1'b1, ICB_OFF_DATA, 32'(w));
      bus(1'b1, ICB_OFF_DATA, 32'h0);
      bus(1'b0, ICB_OFF_STATUS, 32'h0);
      check(r & 32'h4, 32'h4);
      idle_wait();
      cmp_got();
      bus(1'b1, ICB_OFF_ADDR, 32'h10);
      bus(1'b0, ICB_OFF_SETUP, 32'h0);
      check(r, 32'h10);
      icb_unit_model_i.mem[16] = 24'h3;
      icb_unit_model_i.mem[17] = 24'h20;
      icb_unit_model_i.mem[18] = 24'h10002;
      icb_unit_model_i.mem[19] = 24'h30;
      for (int i = 32; i < 35; i++)
      begin
         w = 24'(rnd());
         icb_unit_model_i.mem[i] = w;
         exp_q.push_back(w);
         icb_unit_model_i.mem[i + 13] = 24'h0;
      end
      slow <= 1'b1;
      bus(1'b1, ICB_OFF_CMD, 32'h800000);
      bus(1'b0, ICB_OFF_STATUS, 32'h0);
      check(r & 32'h2, 32'h2);
      bus(1'b1, ICB_OFF_DATA, 32'h0);
      bus(1'b0, ICB_OFF_STATUS, 32'h0);
      check(r & 32'h6, 32'h6);
      idle_wait();
      cmp_got();
      bus(1'b0, ICB_OFF_ADDR, 32'h0);
      check(r, 32'h23);
      bus(1'b1, ICB_OFF_ADDR, 32'h12);
      bus(1'b1, ICB_OFF_CMD, 32'he00000);
      for (int i = 0; i < 3; i++)
      begin
         w = 24'(rnd());
         exp_q.push_back(w);
         push(w);
      end
      idle_wait();
      check(32'(icb_unit_model_i.mem[47]), 32'(exp_q.pop_back()));
      check(32'(icb_unit_model_i.mem[48]), 32'(exp_q.pop_back()));
      check(32'(icb_unit_model_i.mem[46]), 32'h0);
      check(32'(n_init), 32'h2);
      exp_q.delete();
      icb_unit_model_i.got.delete();
      w = 24'(rnd());
      unit_din <= w;
      unit_data_avail <= 1'b1;
      repeat (4) @(posedge clk_sys);
      bus(1'b0, ICB_OFF_DATA, 32'h0);
      check(r, 32'(w));
      bus(1'b0, ICB_OFF_UNIT, 32'h0);
      check(r, 32'(w));
      {unit_data_avail, unit_connected, unit_reconnecting} <= 3'b001;
      repeat (4) @(posedge clk_sys);
      bus(1'b0, ICB_OFF_UNIT, 32'h0);
      check(r, 32'h0);
      bus(1'b0, ICB_OFF_DATA, 32'h0);
      check(r, 32'h0);
      exp_q.push_back(w);
      bus(1'b1, ICB_OFF_DATA, 32'(w));
      repeat (6) @(posedge clk_sys);
      check(32'(unit_data_here), 32'h0);
      unit_connected <= 1'b1;
      idle_wait();
      cmp_got();
      bus(1'b1, ICB_OFF_CTRL, 32'h1);
      bus(1'b0, ICB_OFF_ADDR, 32'h0);
      bus(1'b0, ICB_OFF_STATUS, 32'h0);
      check(r & 32'h4, 32'h4);
      w = 24'(rnd());
      exp_q.push_back(w);
      bus(1'b1, ICB_OFF_ADDR, 32'(w));
      idle_wait();
      w = 24'(rnd());
      icb_unit_model_i.mem[58] = w;
      exp_q.push_back(w);
      unit_addr_in <= 20'h3a;
      unit_xfer_req <= 1'b1;
      repeat (10) @(posedge clk_sys);
      unit_xfer_req <= 1'b0;
      idle_wait();
      cmp_got();
      w = 24'(rnd());
      icb_unit_model_i.mem[20] = 24'h1;
      icb_unit_model_i.mem[21] = 24'h3b;
      icb_unit_model_i.mem[59] = w;
      exp_q.push_back(w);
      unit_count_en <= 1'b1;
      bus(1'b1, ICB_OFF_CTRL, 32'h2);
      bus(1'b1, ICB_OFF_ADDR, 32'h14);
      bus(1'b1, ICB_OFF_CMD, 32'h800000);
      idle_wait();
      unit_xfer_req <= 1'b1;
      repeat (10) @(posedge clk_sys);
      unit_xfer_req <= 1'b0;
      idle_wait();
      cmp_got();
      bus(1'b0, ICB_OFF_ADDR, 32'h0);
      check(r, 32'h3c);
      check(32'(n_wcd), 32'h1);
      tally_and_finish();
   end
endmodule : tb_icb_channel
`default_nettype wire
